/* logic/ests_abort_judge.sv */
// Judge for abort status: decides which abort flags a shutdown event raises.
// Assumes target activity flags from the transfer engine, valid in the same cycle.
`timescale 1ns/1ps
module ests_abort_judge
	import ests_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic shut_req,
	input wire logic clear_all,
	input wire ests_target_t target,
	output logic lost,
	output logic shutoff
);

	// ----------------------------------------------------------------
	// Flag capture
	// ----------------------------------------------------------------
	logic next_lost_hit;
	logic next_shut_hit;

	always_comb begin
		next_lost_hit = target.is_receive && target.addr_match &&
			(target.data_phase || target.stop_seen);
		next_shut_hit = !target.other_master &&
			(target.addr_phase || (target.is_receive && target.data_phase));
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			lost <= 1'b0;
			shutoff <= 1'b0;
		end else if (clear_all) begin
			lost <= 1'b0;
			shutoff <= 1'b0;
		end else if (shut_req) begin
			lost <= lost | next_lost_hit;
			shutoff <= shutoff | next_shut_hit;
		end
	end

endmodule : ests_abort_judge

/* logic/ests_pkg.sv */
// Package for the enable status tracker: register offsets, field positions, reset values, states.
// Assumes a 32-bit word register port and a target-side transfer engine outside the block.
package ests_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ESTS_ADDR_CONTROL = 8'h6c;
	localparam logic [7:0] ESTS_ADDR_STATUS = 8'h9c;
	localparam int ESTS_BIT_ENABLE = 0;
	localparam int ESTS_BIT_ENABLED = 0;
	localparam int ESTS_BIT_SHUTOFF = 1;
	localparam int ESTS_BIT_LOST = 2;
	localparam logic ESTS_RST_CONTROL = 1'b0;
	localparam logic [31:0] ESTS_RST_STATUS = 32'h0000_0000;
	localparam int ESTS_DRAIN_CYCLES = 2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic addr_phase;
		logic data_phase;
		logic addr_match;
		logic is_receive;
		logic other_master;
		logic stop_seen;
		logic nack_sent;
	} ests_target_t;

	typedef enum logic [1:0] {
		ESTS_OFF,
		ESTS_ON,
		ESTS_DRAIN
	} ests_state_t;

endpackage : ests_pkg

/* logic/ests_tracker.sv */
// Top of the enable status tracker: control bit, enabled indicator and status register.
// Assumes a one-cycle strobe register port; read data stand one cycle after the read strobe.
`timescale 1ns/1ps

module ests_tracker
	import ests_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire ests_target_t target,
	input wire logic bus_busy,
	output logic enabled_indicator_output,
	output logic controller_on
);

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	logic controller_on_control;
	logic shut_req;
	logic lost;
	logic shutoff;
	ests_state_t state;
	logic [1:0] drain_count;

	assign shut_req = reg_write && reg_addr == ESTS_ADDR_CONTROL &&
		!reg_wdata[ESTS_BIT_ENABLE] && controller_on_control;

	always_ff @(posedge clock) begin
		if (srst) begin
			controller_on_control <= ESTS_RST_CONTROL;
		end else if (reg_write && reg_addr == ESTS_ADDR_CONTROL) begin
			controller_on_control <= reg_wdata[ESTS_BIT_ENABLE];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			controller_on <= ESTS_RST_CONTROL;
		end else begin
			controller_on <= controller_on_control;
		end
	end

	// ----------------------------------------------------------------
	// Enabled indicator: stays high until bus activity has finished
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			state <= ESTS_OFF;
			drain_count <= 2'h0;
			enabled_indicator_output <= 1'b0;
		end else begin
			case (state)
				ESTS_OFF: begin
					if (controller_on_control) begin
						state <= ESTS_ON;
						enabled_indicator_output <= 1'b1;
					end
				end
				ESTS_ON: begin
					if (!controller_on_control) begin
						state <= ESTS_DRAIN;
						drain_count <= 2'(ESTS_DRAIN_CYCLES);
					end
				end
				default: begin
					if (controller_on_control) begin
						state <= ESTS_ON;
					end else if (bus_busy) begin
						drain_count <= 2'(ESTS_DRAIN_CYCLES);
					end else if (drain_count != 2'h0) begin
						drain_count <= drain_count - 2'h1;
					end else begin
						state <= ESTS_OFF;
						enabled_indicator_output <= 1'b0;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Abort flags
	// ----------------------------------------------------------------
	ests_abort_judge u_judge (
		.clock(clock),
		.srst(srst),
		.shut_req(shut_req),
		.clear_all(controller_on_control && !shut_req),
		.target(target),
		.lost(lost),
		.shutoff(shutoff)
	);

	// ----------------------------------------------------------------
	// Read port; status writes are ignored
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			reg_rdata <= ESTS_RST_STATUS;
		end else if (!reg_read) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_addr == ESTS_ADDR_STATUS) begin
			reg_rdata <= 32'h0000_0000;
			reg_rdata[ESTS_BIT_ENABLED] <= enabled_indicator_output;
			reg_rdata[ESTS_BIT_SHUTOFF] <= shutoff && !controller_on_control;
			reg_rdata[ESTS_BIT_LOST] <= lost && !controller_on_control;
		end else if (reg_addr == ESTS_ADDR_CONTROL) begin
			reg_rdata <= {31'h0, controller_on_control};
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

endmodule : ests_tracker

/* test/ests_remote_master.sv */
// Remote bus master model: target activity levels for one chosen scenario.
// Assumes the bench holds the scenario code steady across a shutdown.
`timescale 1ns/1ps
module ests_remote_master
	import ests_pkg::*;
(
	input wire logic [2:0] mode,
	output ests_target_t target,
	output logic bus_busy
);
	localparam logic [6:0] SCENE [7] = '{7'h00, 7'h38, 7'h1a, 7'h40, 7'h44, 7'h29, 7'h58};
	assign target = SCENE[mode];
	assign bus_busy = (mode != 3'h0);
endmodule : ests_remote_master

/* test/ests_tracker_sva.sv */
// Checker for the enable status tracker.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ests_tracker_sva
	import ests_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic bus_busy,
	input wire logic enabled_indicator_output,
	input wire logic controller_on
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	sequence st_rd;
		$past(reg_read) && $past(reg_addr) == ESTS_ADDR_STATUS;
	endsequence
	idle_zero_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
		else $error("read data not zero");
	resv_zero_a: assert property (reg_rdata[31:3] == 29'h0)
		else $error("reserved bits set");
	unmapped_a: assert property ($past(reg_read) && $past(reg_addr) == 8'h00 |-> !reg_rdata)
		else $error("unmapped read not zero");
	mirror_a: assert property (st_rd |-> reg_rdata[0] == $past(enabled_indicator_output))
		else $error("enabled bit differs");
	on_forced_a: assert property (st_rd ##0 controller_on && $past(controller_on)
		|-> reg_rdata[2:0] == 3'h1) else $error("status not forced");
	on_ind_a: assert property (controller_on |-> enabled_indicator_output)
		else $error("indicator low while on");
	busy_hold_a: assert property (enabled_indicator_output && bus_busy
		|=> enabled_indicator_output) else $error("indicator fell while busy");
	idle_fall_a: assert property ($fell(enabled_indicator_output)
		|-> !controller_on && $past(bus_busy) == 1'b0) else $error("early fall");
	cover property (st_rd ##0 reg_rdata[2]);
	cover property (st_rd ##0 reg_rdata[1]);
	cover property ($fell(enabled_indicator_output));
endmodule : ests_tracker_sva
bind ests_tracker ests_tracker_sva u_sva(.*);

/* test/ests_tracker_tb.sv */
// Bench: shuts the tracker off under every target scenario, then random ones.
// Assumes the remote master model and the bound checker.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
	$display("unexpected %0t %h %h", $time, a, b); end end
module ests_tracker_tb
	import ests_pkg::*;
;
	logic clock = 0, srst = 1, reg_write = 0, reg_read = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
	logic [2:0] mode = 3'h0;
	ests_target_t target;
	logic bus_busy, enabled_indicator_output, controller_on;
	int num_errors = 0, samples_checked = 0;
	ests_tracker dut(.*);
	ests_remote_master peer(.mode(mode), .target(target), .bus_busy(bus_busy));
	initial forever #5 clock = ~clock;
	function automatic logic [31:0] expect_status(ests_target_t t);
		return {29'h0, t.is_receive & t.addr_match & (t.data_phase | t.stop_seen),
			~t.other_master & (t.addr_phase | (t.is_receive & t.data_phase)), 1'b0};
	endfunction : expect_status
	task automatic wr(logic [7:0] a, logic [31:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic shut(logic [2:0] m);
		logic [31:0] e;
		wr(ESTS_ADDR_CONTROL, 32'h1);
		rd(ESTS_ADDR_STATUS);
		`CHK(d, 32'h1)
		`CHK(controller_on, 1'b1)
		rd(ESTS_ADDR_CONTROL);
		`CHK(d, 32'h1)
		mode <= m;
		wr(ESTS_ADDR_STATUS, 32'hffff_ffff);
		e = expect_status(target);
		wr(ESTS_ADDR_CONTROL, 32'h0);
		repeat ($urandom_range(3, 0)) @(posedge clock);
		mode <= 3'h0;
		for (int i = 0; i < 20 && d[0] !== 1'b0; i++) rd(ESTS_ADDR_STATUS);
		`CHK(d, e)
		`CHK(controller_on, 1'b0)
	endtask : shut
	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	initial begin
		void'($urandom(29001));
		repeat (20) @(posedge clock);
		srst <= 1'b0;
		rd(8'h00);
		`CHK(d, 32'h0)
		for (int m = 0; m < 7; m++) shut(3'(m));
		repeat (20) shut(3'($urandom_range(6, 0)));
		stop_test();
	end
	initial begin
		#100000;
		num_errors++;
		stop_test();
	end
endmodule : ests_tracker_tb
